// File: bslrd_row_driver.sv
`timescale 1ns/10ps
module bslrd_row_driver (
  input  wire logic               mclk,
  input  wire logic               reset,
  // serial row interface pins
  input  wire logic               transferClk,
  input  wire logic               shiftDirectionSelect,
  input  wire logic               registerClear_n,
  input  wire logic               oddLatchStrobe,
  input  wire logic               evenLatchStrobe,
  input  wire logic               outputDriveEnable_n,
  input  wire logic               forceLowBlank_n,
  input  wire logic               forceHighBlank,
  input  wire logic               leftSerialIn,
  output logic                    leftSerialOut,
  output logic                    leftSerialOe,
  input  wire logic               rightSerialIn,
  output logic                    rightSerialOut,
  output logic                    rightSerialOe,
  output bslrd_pkg::bslrd_row_t   driverOutputs,
  output bslrd_pkg::bslrd_row_t   driverOutputsOe,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata
);
  import bslrd_pkg::*;

  logic [PIN_COUNT-1:0]   pinMetaQ;
  logic [PIN_COUNT-1:0]   pinSyncQ;
  logic [PIN_COUNT-1:0]   pinRaw;
  logic                   xferClkDlyQ;
  logic                   xferRise;
  logic                   dirS;
  logic                   clearActive;
  bslrd_row_t             shiftQ;
  bslrd_row_t             latchQ;
  logic [CTRL_WIDTH-1:0]  ctrlQ;
  logic                   wrPendQ;
  logic [7:0]             wrAddrQ;
  logic                   addrPhase;
  logic [CTRL_WIDTH-1:0]  ctrlView;
  logic [31:0]            rdData;

  bslrd_drive_if drv ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, two flops before any logic
  always_comb begin
    pinRaw               = '0;
    pinRaw[PIN_XFER_CLK] = transferClk;
    pinRaw[PIN_LEFT_IN]  = leftSerialIn;
    pinRaw[PIN_RIGHT_IN] = rightSerialIn;
    pinRaw[PIN_DIR]      = shiftDirectionSelect;
    pinRaw[PIN_CLEAR_N]  = registerClear_n;
    pinRaw[PIN_ODD_STB]  = oddLatchStrobe;
    pinRaw[PIN_EVEN_STB] = evenLatchStrobe;
    pinRaw[PIN_OE_N]     = outputDriveEnable_n;
    pinRaw[PIN_LBLANK_N] = forceLowBlank_n;
    pinRaw[PIN_HBLANK]   = forceHighBlank;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinMetaQ <= PIN_RESET;
      pinSyncQ <= PIN_RESET;
    end else begin
      pinMetaQ <= pinRaw;
      pinSyncQ <= pinMetaQ;
    end
  end

  // data pins share the clock's latency, so sampling stays aligned
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      xferClkDlyQ <= 1'b0;
    end else begin
      xferClkDlyQ <= pinSyncQ[PIN_XFER_CLK];
    end
  end

  assign xferRise    = pinSyncQ[PIN_XFER_CLK] & ~xferClkDlyQ;
  assign dirS        = pinSyncQ[PIN_DIR];
  assign clearActive = ~pinSyncQ[PIN_CLEAR_N] | ctrlQ[CTRL_SOFT_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // shift chain: shiftQ[0] is stage 1, shiftQ[STAGES-1] is stage 64
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shiftQ <= '0;
    end else if (clearActive) begin
      shiftQ <= '0;
    end else if (xferRise) begin
      if (!dirS) begin
        shiftQ <= {shiftQ[STAGES-2:0], pinSyncQ[PIN_LEFT_IN]};
      end else begin
        shiftQ <= {pinSyncQ[PIN_RIGHT_IN], shiftQ[STAGES-1:1]};
      end
    end
  end

  // one mclk pulse per pin edge, so a long high phase shifts once
  chk_single_rise: assert property (@(posedge mclk) disable iff (reset)
    xferRise |=> !xferRise)
    else $error("transfer edge seen twice");

  // four samples cover both sync flops from the raw pin
  sequence clearPin4;
    !registerClear_n [*4];
  endsequence

  chk_clear_pin: assert property (@(posedge mclk) disable iff (reset)
    clearPin4 |=> shiftQ == '0)
    else $error("clear pin did not empty the chain");

  ////////////////////////////////////////////////////////////////////////////
  // cascade ports; the idle end is released so the feeder may drive it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      leftSerialOut  <= 1'b0;
      leftSerialOe   <= 1'b0;
      rightSerialOut <= 1'b0;
      rightSerialOe  <= 1'b0;
    end else begin
      leftSerialOut  <= shiftQ[0];
      leftSerialOe   <= dirS;
      rightSerialOut <= shiftQ[STAGES-1];
      rightSerialOe  <= ~dirS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latches; stage 1 (index 0) counts as odd
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_latch
      localparam int STB = (i % 2 == 0) ? PIN_ODD_STB : PIN_EVEN_STB;
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          latchQ[i] <= 1'b0;
        end else if (!pinSyncQ[STB]) begin
          latchQ[i] <= shiftQ[i];
        end
      end
    end
  endgenerate

  chk_odd_pass: assert property (@(posedge mclk) disable iff (reset)
    !pinSyncQ[PIN_ODD_STB] |=> latchQ[0] == $past(shiftQ[0]) &&
                               latchQ[62] == $past(shiftQ[62]))
    else $error("odd latch not transparent while strobe low");

  sequence evenHeld2;
    pinSyncQ[PIN_EVEN_STB] [*2];
  endsequence

  chk_even_hold: assert property (@(posedge mclk) disable iff (reset)
    evenHeld2 |-> latchQ[1] == $past(latchQ[1]) &&
                  latchQ[63] == $past(latchQ[63]))
    else $error("even latch changed while strobe high");

  ////////////////////////////////////////////////////////////////////////////
  // output stage
  assign drv.latchBits  = latchQ;
  assign drv.outEnableN = pinSyncQ[PIN_OE_N] & ~ctrlQ[CTRL_SOFT_OFF];
  assign drv.lowBlankN  = pinSyncQ[PIN_LBLANK_N];
  assign drv.highBlank  = pinSyncQ[PIN_HBLANK];

  bslrd_output_stage u_stage (
    .mclk  (mclk),
    .reset (reset),
    .drv   (drv.stage)
  );

  assign driverOutputs   = drv.drvOut;
  assign driverOutputsOe = drv.drvOe;

  // pin to driver takes two sync flops plus the output flop
  sequence pinOff4;
    !outputDriveEnable_n [*4];
  endsequence

  sequence lowBlank4;
    (outputDriveEnable_n && !forceLowBlank_n) [*4];
  endsequence

  sequence highBlank4;
    (outputDriveEnable_n && forceLowBlank_n && forceHighBlank) [*4];
  endsequence

  chk_pin_disable: assert property (@(posedge mclk) disable iff (reset)
    pinOff4 |=> driverOutputsOe == '0)
    else $error("disable pin did not release the outputs");

  chk_force_low: assert property (@(posedge mclk) disable iff (reset)
    lowBlank4 ##0 !ctrlQ[CTRL_SOFT_OFF] |=>
      driverOutputsOe == '1 && driverOutputs == '0)
    else $error("low blank pin did not pull the outputs low");

  chk_force_high: assert property (@(posedge mclk) disable iff (reset)
    highBlank4 ##0 !ctrlQ[CTRL_SOFT_OFF] |=>
      driverOutputsOe == '1 && driverOutputs == '1)
    else $error("high blank pin did not drive the outputs high");

  chk_soft_off: assert property (@(posedge mclk) disable iff (reset)
    ctrlQ[CTRL_SOFT_OFF] |=> driverOutputsOe == '0)
    else $error("soft off left outputs driven");

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data registered at address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel & hready & htrans[1];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
    end else if (hready) begin
      wrPendQ <= addrPhase & hwrite;
      wrAddrQ <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrlQ <= CTRL_RESET;
    end else if (wrPendQ && wrAddrQ == ADDR_CTRL) begin
      ctrlQ <= hwdata[CTRL_WIDTH-1:0];
    end
  end

  // a read right behind a write to control sees the new value
  assign ctrlView = (wrPendQ && wrAddrQ == ADDR_CTRL) ?
                    hwdata[CTRL_WIDTH-1:0] : ctrlQ;

  always_comb begin
    rdData = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_CTRL:     rdData[CTRL_WIDTH-1:0] = ctrlView;
      ADDR_SHIFT_LO: rdData = shiftQ[31:0];
      ADDR_SHIFT_HI: rdData = shiftQ[63:32];
      ADDR_LATCH_LO: rdData = latchQ[31:0];
      ADDR_LATCH_HI: rdData = latchQ[63:32];
      ADDR_PINS:     rdData[PIN_COUNT-1:0] = pinSyncQ;
      default:       rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdData;
    end
  end

  // write data lands one cycle after its address phase
  sequence ctrlWrite;
    addrPhase && hwrite && haddr[7:0] == ADDR_CTRL ##1 1'b1;
  endsequence

  chk_ctrl_write: assert property (@(posedge mclk) disable iff (reset)
    ctrlWrite |=> ctrlQ == $past(hwdata[CTRL_WIDTH-1:0]))
    else $error("control write lost");

  chk_read_shift: assert property (@(posedge mclk) disable iff (reset)
    addrPhase && !hwrite && haddr[7:0] == ADDR_SHIFT_LO |=>
      hrdata == $past(shiftQ[31:0]))
    else $error("read data is not the low chain word");

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_clear_empties: assert property (@(posedge mclk) disable iff (reset)
    clearActive |=> shiftQ == '0)
    else $error("chain not cleared");

  chk_hold_no_edge: assert property (@(posedge mclk) disable iff (reset)
    !clearActive && !xferRise |=> shiftQ == $past(shiftQ))
    else $error("chain moved without a transfer clock edge");

  chk_left_shift: assert property (@(posedge mclk) disable iff (reset)
    !clearActive && xferRise && !dirS |=>
      shiftQ == {$past(shiftQ[STAGES-2:0]), $past(pinSyncQ[PIN_LEFT_IN])})
    else $error("left shift wrong");

  chk_right_shift: assert property (@(posedge mclk) disable iff (reset)
    !clearActive && xferRise && dirS |=>
      shiftQ == {$past(pinSyncQ[PIN_RIGHT_IN]), $past(shiftQ[STAGES-1:1])})
    else $error("right shift wrong");

  chk_left_mode_ports: assert property (@(posedge mclk) disable iff (reset)
    !dirS |=> !leftSerialOe && rightSerialOe &&
              rightSerialOut == $past(shiftQ[STAGES-1]))
    else $error("left mode port roles wrong");

  chk_right_mode_ports: assert property (@(posedge mclk) disable iff (reset)
    dirS |=> leftSerialOe && !rightSerialOe &&
             leftSerialOut == $past(shiftQ[0]))
    else $error("right mode port roles wrong");

  sequence oddHeld2;
    pinSyncQ[PIN_ODD_STB] [*2];
  endsequence

  sequence evenOpen;
    !pinSyncQ[PIN_EVEN_STB];
  endsequence

  chk_odd_latch_hold: assert property (@(posedge mclk) disable iff (reset)
    oddHeld2 |-> latchQ[0] == $past(latchQ[0]) &&
                 latchQ[62] == $past(latchQ[62]))
    else $error("odd latch changed while strobe high");

  chk_even_latch_pass: assert property (@(posedge mclk) disable iff (reset)
    evenOpen |=> latchQ[1] == $past(shiftQ[1]) &&
                 latchQ[63] == $past(shiftQ[63]))
    else $error("even latch not transparent while strobe low");

endmodule : bslrd_row_driver

// File: bslrd_pkg.sv
package bslrd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // chain geometry
  localparam int          STAGES        = 64;
  localparam int          PIN_COUNT     = 10;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SHIFT_LO = 8'h04;
  localparam logic [7:0]  ADDR_SHIFT_HI = 8'h08;
  localparam logic [7:0]  ADDR_LATCH_LO = 8'h0c;
  localparam logic [7:0]  ADDR_LATCH_HI = 8'h10;
  localparam logic [7:0]  ADDR_PINS     = 8'h14;

  // control fields
  localparam int          CTRL_SOFT_CLEAR = 0;
  localparam int          CTRL_SOFT_OFF   = 1;
  localparam int          CTRL_WIDTH      = 2;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // synchronised pin vector layout
  localparam int          PIN_XFER_CLK  = 0;
  localparam int          PIN_LEFT_IN   = 1;
  localparam int          PIN_RIGHT_IN  = 2;
  localparam int          PIN_DIR       = 3;
  localparam int          PIN_CLEAR_N   = 4;
  localparam int          PIN_ODD_STB   = 5;
  localparam int          PIN_EVEN_STB  = 6;
  localparam int          PIN_OE_N      = 7;
  localparam int          PIN_LBLANK_N  = 8;
  localparam int          PIN_HBLANK    = 9;
  // all zero: register cleared, outputs high impedance
  localparam logic [9:0]  PIN_RESET     = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          CLK_MHZ              = 200;
  localparam int          XFER_CLK_MAX_MHZ     = 12;
  localparam int          XFER_MIN_PERIOD_CYC  =
    (CLK_MHZ + XFER_CLK_MAX_MHZ - 1) / XFER_CLK_MAX_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [STAGES-1:0] bslrd_row_t;

  typedef enum logic [1:0] {
    DRV_HIZ  = 2'b00,
    DRV_LOW  = 2'b01,
    DRV_HIGH = 2'b10,
    DRV_DATA = 2'b11
  } bslrd_drive_mode_t;

endpackage : bslrd_pkg

// File: bslrd_drive_if.sv
`timescale 1ns/10ps
interface bslrd_drive_if;
  import bslrd_pkg::*;

  bslrd_row_t latchBits;
  logic       outEnableN;
  logic       lowBlankN;
  logic       highBlank;
  bslrd_row_t drvOut;
  bslrd_row_t drvOe;

  modport ctrl (
    output latchBits,
    output outEnableN,
    output lowBlankN,
    output highBlank,
    input  drvOut,
    input  drvOe
  );

  modport stage (
    input  latchBits,
    input  outEnableN,
    input  lowBlankN,
    input  highBlank,
    output drvOut,
    output drvOe
  );
endinterface : bslrd_drive_if

// File: bslrd_output_stage.sv
`timescale 1ns/10ps
module bslrd_output_stage (
  input wire logic mclk,
  input wire logic reset,
  bslrd_drive_if.stage drv
);
  import bslrd_pkg::*;

  bslrd_drive_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // override priority: hi-z, then low blank, then high blank
  always_comb begin
    if (!drv.outEnableN) begin
      mode = DRV_HIZ;
    end else if (!drv.lowBlankN) begin
      mode = DRV_LOW;
    end else if (drv.highBlank) begin
      mode = DRV_HIGH;
    end else begin
      mode = DRV_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_drv
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          drv.drvOut[i] <= 1'b0;
          drv.drvOe[i]  <= 1'b0;
        end else begin
          case (mode)
            DRV_HIZ: begin
              drv.drvOut[i] <= 1'b0;
              drv.drvOe[i]  <= 1'b0;
            end
            DRV_LOW: begin
              drv.drvOut[i] <= 1'b0;
              drv.drvOe[i]  <= 1'b1;
            end
            DRV_HIGH: begin
              drv.drvOut[i] <= 1'b1;
              drv.drvOe[i]  <= 1'b1;
            end
            DRV_DATA: begin
              // drivers invert the latch
              drv.drvOut[i] <= ~drv.latchBits[i];
              drv.drvOe[i]  <= 1'b1;
            end
            default: begin
              drv.drvOut[i] <= 1'b0;
              drv.drvOe[i]  <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  chk_hiz_wins: assert property (@(posedge mclk) disable iff (reset)
    !drv.outEnableN |=> drv.drvOe == '0)
    else $error("outputs not high impedance while disabled");

  chk_low_blank: assert property (@(posedge mclk) disable iff (reset)
    drv.outEnableN && !drv.lowBlankN |=>
      drv.drvOe == '1 && drv.drvOut == '0)
    else $error("low blank did not drive all outputs low");

  chk_high_blank: assert property (@(posedge mclk) disable iff (reset)
    drv.outEnableN && drv.lowBlankN && drv.highBlank |=>
      drv.drvOe == '1 && drv.drvOut == '1)
    else $error("high blank did not drive all outputs high");

  chk_data_inverted: assert property (@(posedge mclk) disable iff (reset)
    drv.outEnableN && drv.lowBlankN && !drv.highBlank |=>
      drv.drvOe == '1 && drv.drvOut == ~$past(drv.latchBits))
    else $error("driver output is not the inverse of the latch");

endmodule : bslrd_output_stage

// File: bslrd_feeder.sv
`timescale 1ns/10ps
module bslrd_feeder (
  input  wire logic mclk,
  input  wire logic dirSel,
  output logic      transferClk,
  output logic      leftData,
  output logic      rightData
);
  import bslrd_pkg::*;

  // 1 + 6 + 9 + 3 = 19 mclk per bit, above the 17-cycle floor
  localparam int SETUP_CYC = 6;
  localparam int HIGH_CYC  = 9;
  localparam int TAIL_CYC  = 3;

  logic lastBit;

  initial begin
    transferClk = 1'b0;
    leftData    = 1'b0;
    rightData   = 1'b0;
    lastBit     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit i of word goes out i-th; clock idles low between frames
  task automatic send(input bslrd_row_t word, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lastBit = word[i];
      if (dirSel) rightData <= word[i];
      else leftData <= word[i];
      repeat (SETUP_CYC) @(posedge mclk);
      transferClk <= 1'b1;
      repeat (HIGH_CYC) @(posedge mclk);
      transferClk <= 1'b0;
      repeat (TAIL_CYC) @(posedge mclk);
    end
    // released line flips so a stale bit can never look valid
    leftData  <= ~lastBit;
    rightData <= ~lastBit;
  endtask : send
endmodule : bslrd_feeder

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  import bslrd_pkg::*;

  typedef struct packed {
    logic              oeN;
    logic              lbN;
    logic              hb;
    bslrd_drive_mode_t mode;
  } bslrd_case_t;

  logic        mclk, reset, dirSel, regClear_n, oddStb, evenStb;
  logic        outEnable_n, lowBlank_n, highBlank, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd, rd2;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic  xferClk, fLeft, fRight, leftWire, rightWire;
  wire  logic  leftOut, leftOe, rightOut, rightOe, hready, hresp;
  wire  logic [31:0] hrdata;
  bslrd_row_t  driverOutputs, driverOutputsOe, wordA, wordB, expLatch;
  bslrd_row_t  expOut, expOe, seenRow;
  int          err_total, checked, cycles;
  localparam bslrd_row_t ODD_MASK = 64'h5555_5555_5555_5555;
  bslrd_case_t rows [6] = '{
    '{1'b0, 1'b0, 1'b1, DRV_HIZ}, '{1'b0, 1'b1, 1'b0, DRV_HIZ},
    '{1'b1, 1'b0, 1'b1, DRV_LOW}, '{1'b1, 1'b0, 1'b0, DRV_LOW},
    '{1'b1, 1'b1, 1'b1, DRV_HIGH}, '{1'b1, 1'b1, 1'b0, DRV_DATA}};

  // wire level follows whoever has its enable up
  assign leftWire  = leftOe ? leftOut : fLeft;
  assign rightWire = rightOe ? rightOut : fRight;

  bslrd_row_driver u_bslrd_row_driver (
    .mclk(mclk), .reset(reset), .transferClk(xferClk),
    .shiftDirectionSelect(dirSel), .registerClear_n(regClear_n),
    .oddLatchStrobe(oddStb), .evenLatchStrobe(evenStb),
    .outputDriveEnable_n(outEnable_n), .forceLowBlank_n(lowBlank_n),
    .forceHighBlank(highBlank), .leftSerialIn(leftWire),
    .leftSerialOut(leftOut), .leftSerialOe(leftOe),
    .rightSerialIn(rightWire), .rightSerialOut(rightOut),
    .rightSerialOe(rightOe), .driverOutputs(driverOutputs),
    .driverOutputsOe(driverOutputsOe), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));

  bslrd_feeder u_feeder (
    .mclk(mclk), .dirSel(dirSel), .transferClk(xferClk),
    .leftData(fLeft), .rightData(fRight));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input bslrd_row_t seen,
                       input bslrd_row_t exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // one single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] data);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    data = hrdata;
    #1;
    check("hresp", {63'h0, hresp}, 64'h0);
  endtask : bus

  task automatic read_pair(input logic [7:0] a, output bslrd_row_t v);
    bus(1'b0, a, 32'h0, rd);
    bus(1'b0, a + 8'h04, 32'h0, rd2);
    v = {rd2, rd};
  endtask : read_pair

  function automatic bslrd_row_t flip(input bslrd_row_t v);
    bslrd_row_t r;
    for (int i = 0; i < STAGES; i++) r[i] = v[STAGES-1-i];
    return r;
  endfunction : flip

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, dirSel, oddStb, evenStb, highBlank, hsel, hwrite} = '0;
    {regClear_n, outEnable_n, lowBlank_n} = 3'b111;
    {haddr, hwdata, htrans, hsize, err_total, checked, cycles} = '0;
    wordA = 64'hc3a5_0f1e_9b27_6d48;
    wordB = 64'h1e2d_3c4b_5a69_7887;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    hsize <= 3'b010;
    settle(5);
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", {32'h0, rd}, {62'h0, CTRL_RESET});
    bus(1'b1, ADDR_CTRL, 32'h3, rd);
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl rw", {32'h0, rd}, 64'h3);
    bus(1'b1, ADDR_CTRL, 32'h0, rd);
    bus(1'b0, 8'h18, 32'h0, rd);
    check("unmapped", {32'h0, rd}, 64'h0);
    // left shift: first bit sent ends in stage 64
    u_feeder.send(wordA, STAGES);
    settle(6);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("shift left", seenRow, flip(wordA));
    check("right out", {62'h0, rightOe, rightOut}, {62'h0, 1'b1, wordA[0]});
    check("left oe", {63'h0, leftOe}, 64'h0);
    settle(30);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("shift hold", seenRow, flip(wordA));
    read_pair(ADDR_LATCH_LO, seenRow);
    check("latch through", seenRow, flip(wordA));
    check("drv data", driverOutputs, ~flip(wordA));
    @(posedge mclk);
    oddStb  <= 1'b1;
    evenStb <= 1'b1;
    settle(6);
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      outEnable_n <= rows[k].oeN;
      lowBlank_n  <= rows[k].lbN;
      highBlank   <= rows[k].hb;
      settle(6);
      expOe  = (rows[k].mode == DRV_HIZ) ? '0 : '1;
      expOut = (rows[k].mode == DRV_HIGH) ? '1 :
               (rows[k].mode == DRV_DATA) ? ~flip(wordA) : '0;
      check("drv oe", driverOutputsOe, expOe);
      check("drv out", driverOutputs, expOut);
    end
    // right shift with only even latches open
    @(posedge mclk);
    dirSel  <= 1'b1;
    evenStb <= 1'b0;
    settle(6);
    u_feeder.send(wordB, STAGES);
    settle(6);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("shift right", seenRow, wordB);
    check("left out", {62'h0, leftOe, leftOut}, {62'h0, 1'b1, wordB[0]});
    check("right oe", {63'h0, rightOe}, 64'h0);
    expLatch = (flip(wordA) & ODD_MASK) | (wordB & ~ODD_MASK);
    read_pair(ADDR_LATCH_LO, seenRow);
    check("latch split", seenRow, expLatch);
    check("drv split", driverOutputs, ~expLatch);
    // clocks during clear must not load anything
    @(posedge mclk);
    regClear_n <= 1'b0;
    u_feeder.send('1, 2);
    settle(6);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("clear", seenRow, 64'h0);
    read_pair(ADDR_LATCH_LO, seenRow);
    check("latch clear", seenRow, flip(wordA) & ODD_MASK);
    @(posedge mclk);
    regClear_n <= 1'b1;
    settle(6);
    u_feeder.send(64'h5, 3);
    settle(6);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("partial", seenRow, 64'ha000_0000_0000_0000);
    // soft clear and soft off, then a reset in mid-run undoes both
    bus(1'b1, ADDR_CTRL, 32'h3, rd);
    settle(2);
    check("soft off", driverOutputsOe, 64'h0);
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("soft clear", seenRow, 64'h0);
    // dir, clear_n, odd strobe, enable_n and low blank_n stand high
    bus(1'b0, ADDR_PINS, 32'h0, rd);
    check("pins", {32'h0, rd}, 64'h1b8);
    @(posedge mclk);
    reset <= 1'b1;
    settle(1);
    check("reset oe", driverOutputsOe, 64'h0);
    check("reset ports", {62'h0, leftOe, rightOe}, 64'h0);
    check("reset hrdata", {32'h0, hrdata}, 64'h0);
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    settle(6);
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl after reset", {32'h0, rd}, {62'h0, CTRL_RESET});
    read_pair(ADDR_SHIFT_LO, seenRow);
    check("reset chain", seenRow, 64'h0);
    check("reset drive", driverOutputs & driverOutputsOe, '1);
    end_of_test();
  end
endmodule : testbench
